// *** rtl/cmp_dac_defines.svh ***
// Register indices, field positions, reset values and filter timing.
`ifndef CMP_DAC_DEFINES_SVH
`define CMP_DAC_DEFINES_SVH

`define IDX_W              16
`define IDX_THRESHOLD_TWO  16'ha03b
`define IDX_DAC_CONFIG     16'ha03c
`define IDX_CMP_STATUS     16'ha03d
`define IDX_IRQ_STATUS     16'ha03e
`define IDX_IRQ_MASK       16'ha03f

`define AXI_ADDR_W         18

`define RST_THRESHOLD_TWO  8'h00
`define RST_DAC_CONFIG     8'h00
`define RST_CMP_STATUS     4'h0
`define RST_IRQ            4'h0

`define CFG_DAC_ON_BIT     7
`define CFG_SUPPLY_BIT     6
`define CFG_LOOPBACK_BIT   5
`define CFG_WRITE_MASK     8'hef

`define ST_FLAG_LSB        4
`define FILTER_LEN         16

`endif

// *** rtl/cmp_dac_pkg.sv ***
// Types shared by the comparator and threshold DAC control block.
package cmp_dac_pkg;

  typedef enum logic [1:0] {
    resp_okay   = 2'b00,
    resp_slverr = 2'b10,
    resp_decerr = 2'b11
  } axi_resp_e;

  typedef logic [7:0] reg_byte_t;

endpackage

// *** rtl/reg_access_if.sv ***
// Register access strobes between the bus slave and the register file.
`timescale 1ns/1ns
interface reg_access_if;
  logic                 wr_req;
  logic [15:0]          wr_idx;
  cmp_dac_pkg::reg_byte_t wr_data;
  logic                 wr_lane;
  logic                 wr_ok;
  logic                 rd_req;
  logic [15:0]          rd_idx;
  cmp_dac_pkg::reg_byte_t rd_data;
  logic                 rd_ok;

  modport bus  (output wr_req, wr_idx, wr_data, wr_lane, rd_req, rd_idx,
                input  wr_ok, rd_data, rd_ok);
  modport regs (input  wr_req, wr_idx, wr_data, wr_lane, rd_req, rd_idx,
                output wr_ok, rd_data, rd_ok);
endinterface

// *** rtl/cmp_filter_if.sv ***
// Raw and filtered comparator levels between register file and filter.
`timescale 1ns/1ns
interface cmp_filter_if;
  logic [3:0] raw;
  logic [3:0] filter_on;
  logic [3:0] filtered;

  modport ctrl   (output raw, filter_on, input filtered);
  modport filter (input raw, filter_on, output filtered);
endinterface

// *** rtl/cmp_glitch_filter.sv ***
// Per-comparator digital filter accepting a level after a stable run.
`timescale 1ns/1ns
`include "cmp_dac_defines.svh"
module cmp_glitch_filter #(
  parameter int LEN = `FILTER_LEN
) (
  input  wire logic     clk,
  input  wire logic     srst,
  cmp_filter_if.filter  fio
);
  localparam int CW = $clog2(LEN);
  localparam logic [CW-1:0] LAST = CW'(LEN - 1);

  logic [CW-1:0] run_cnt [4];

  // A level that differs from the accepted one must hold LEN cycles.
  always_ff @(posedge clk) begin
    if (srst) begin
      fio.filtered <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        run_cnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!fio.filter_on[i]) begin
          fio.filtered[i] <= fio.raw[i];
          run_cnt[i]      <= '0;
        end else if (fio.raw[i] == fio.filtered[i]) begin
          run_cnt[i] <= '0;
        end else if (run_cnt[i] == LAST) begin
          fio.filtered[i] <= fio.raw[i]; // [RULE10]
          run_cnt[i]      <= '0;
        end else begin
          run_cnt[i] <= run_cnt[i] + 1'b1;
        end
      end
    end
  end
endmodule

// *** rtl/axil_reg_slave.sv ***
// AXI4-Lite slave that turns bus transfers into register strobes.
`timescale 1ns/1ns
`include "cmp_dac_defines.svh"
module axil_reg_slave #(
  parameter int ADDR_W = `AXI_ADDR_W
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output      logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output      logic              wready,
  output      logic [1:0]        bresp,
  output      logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output      logic              arready,
  output      logic [31:0]       rdata,
  output      logic [1:0]        rresp,
  output      logic              rvalid,
  input  wire logic              rready,
  reg_access_if.bus              rio
);
  logic aw_held;
  logic w_held;
  logic ar_held;

  assign rio.wr_req = aw_held && w_held && !bvalid;
  assign rio.rd_req = ar_held && !rvalid;

  always_ff @(posedge clk) begin
    if (srst) begin
      aw_held     <= 1'b0;
      awready     <= 1'b1;
      rio.wr_idx  <= '0;
    end else if (awvalid && awready) begin
      aw_held    <= 1'b1;
      awready    <= 1'b0;
      rio.wr_idx <= awaddr[17:2];
    end else if (bvalid && bready) begin
      aw_held <= 1'b0;
      awready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      w_held      <= 1'b0;
      wready      <= 1'b1;
      rio.wr_data <= '0;
      rio.wr_lane <= 1'b0;
    end else if (wvalid && wready) begin
      w_held      <= 1'b1;
      wready      <= 1'b0;
      rio.wr_data <= wdata[7:0];
      rio.wr_lane <= wstrb[0];
    end else if (bvalid && bready) begin
      w_held <= 1'b0;
      wready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bvalid <= 1'b0;
      bresp  <= cmp_dac_pkg::resp_okay;
    end else if (rio.wr_req) begin
      bvalid <= 1'b1;
      bresp  <= rio.wr_ok ? cmp_dac_pkg::resp_okay
                          : cmp_dac_pkg::resp_decerr;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ar_held    <= 1'b0;
      arready    <= 1'b1;
      rio.rd_idx <= '0;
    end else if (arvalid && arready) begin
      ar_held    <= 1'b1;
      arready    <= 1'b0;
      rio.rd_idx <= araddr[17:2];
    end else if (rvalid && rready) begin
      ar_held <= 1'b0;
      arready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= cmp_dac_pkg::resp_okay;
    end else if (rio.rd_req) begin
      rvalid <= 1'b1;
      rdata  <= {24'h00_0000, rio.rd_data};
      rresp  <= rio.rd_ok ? cmp_dac_pkg::resp_okay
                          : cmp_dac_pkg::resp_decerr;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

// *** rtl/comparator_status_dac_ctrl.sv ***
// Control and status registers for four comparators and the threshold DAC.
//
// How it works
// RULE1 - An 8-bit code sets the second threshold linearly from zero to full scale.
// RULE2 - Software should write zero to the code when the threshold is unused.
// RULE3 - The same code also sets the level on the DAC voltage output.
// RULE4 - Event flags in bits 7..4 set on an enabled comparator toggle.
// RULE5 - Live output bits read zero whenever their comparator is disabled.
// RULE6 - Low status bits read live outputs, but writes set filter enables.
// RULE7 - Supply-test bit connects the core supply to comparator A input.
// RULE8 - DAC test bit loops the DAC output to converter channel B.
// RULE9 - Threshold, status and DAC configuration registers reset to zero.
// RULE10 - Filtered output changes only after sixteen stable cycles at a new level.
// RULE11 - Writing zero clears an event flag; one keeps it; toggles win.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ns
`include "cmp_dac_defines.svh"
module comparator_status_dac_ctrl #(
  parameter int ADDR_W     = `AXI_ADDR_W,
  parameter int FILTER_LEN = `FILTER_LEN
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output      logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output      logic              wready,
  output      logic [1:0]        bresp,
  output      logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output      logic              arready,
  output      logic [31:0]       rdata,
  output      logic [1:0]        rresp,
  output      logic              rvalid,
  input  wire logic              rready,
  input  wire logic [3:0]        cmp_raw,
  input  wire logic [3:0]        cmp_enable,
  output      logic [7:0]        dac_code,
  output      logic              dac_output_on,
  output      logic              core_supply_to_cmp_a,
  output      logic              dac_loopback_test,
  output      logic [3:0]        hysteresis_on,
  output      logic              irq
);
  reg_access_if rio ();
  cmp_filter_if fio ();

  cmp_dac_pkg::reg_byte_t threshold_two_code;
  cmp_dac_pkg::reg_byte_t dac_config;
  logic [3:0]             event_flag;
  logic [3:0]             filter_on;
  logic [3:0]             irq_status;
  logic [3:0]             irq_mask;
  logic [3:0]             live_prev;
  logic [3:0]             enable_prev;
  logic [3:0]             live_out;
  logic [3:0]             toggle;
  logic                   wr_threshold;
  logic                   wr_config;
  logic                   wr_status;
  logic                   wr_irq_status;
  logic                   wr_irq_mask;
  logic                   wr_go;
  cmp_dac_pkg::reg_byte_t next_code;
  cmp_dac_pkg::reg_byte_t next_cfg;

  // Protection attributes carry no meaning for these registers.
  logic unused_prot;
  assign unused_prot = ^{awprot, arprot};

  function automatic logic reg_hit(input logic [15:0] idx);
    reg_hit = (idx == `IDX_THRESHOLD_TWO) || (idx == `IDX_DAC_CONFIG) ||
              (idx == `IDX_CMP_STATUS)    || (idx == `IDX_IRQ_STATUS) ||
              (idx == `IDX_IRQ_MASK);
  endfunction

  // Every input is an argument, so continuous uses track all of them.
  function automatic logic wr_sel(input logic [15:0] idx,
                                  input logic [15:0] want);
    wr_sel = (idx == want);
  endfunction

  axil_reg_slave #(
    .ADDR_W (ADDR_W)
  ) u_bus (
    .clk     (clk),
    .srst    (srst),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .rio     (rio.bus)
  );

  assign fio.raw       = cmp_raw;
  assign fio.filter_on = filter_on;

  cmp_glitch_filter #(
    .LEN (FILTER_LEN)
  ) u_filter (
    .clk  (clk),
    .srst (srst),
    .fio  (fio.filter)
  );

  assign wr_go         = rio.wr_req && rio.wr_lane;
  assign wr_threshold  = wr_go && wr_sel(rio.wr_idx, `IDX_THRESHOLD_TWO);
  assign wr_config     = wr_go && wr_sel(rio.wr_idx, `IDX_DAC_CONFIG);
  assign wr_status     = wr_go && wr_sel(rio.wr_idx, `IDX_CMP_STATUS);
  assign wr_irq_status = wr_go && wr_sel(rio.wr_idx, `IDX_IRQ_STATUS);
  assign wr_irq_mask   = wr_go && wr_sel(rio.wr_idx, `IDX_IRQ_MASK);
  assign rio.wr_ok     = reg_hit(rio.wr_idx);
  assign rio.rd_ok     = reg_hit(rio.rd_idx);

  // A disabled comparator shows a low live level.
  assign live_out = fio.filtered & cmp_enable; // [RULE5] [RULE10]

  // A toggle counts only while the comparator stays enabled across it.
  assign toggle = (live_out ^ live_prev) & cmp_enable & enable_prev; // [RULE4]

  always_ff @(posedge clk) begin
    if (srst) begin
      live_prev   <= 4'h0;
      enable_prev <= 4'h0;
    end else begin
      live_prev   <= live_out;
      enable_prev <= cmp_enable;
    end
  end

  // One code feeds both the second threshold and the voltage output.
  always_ff @(posedge clk) begin
    if (srst) begin
      threshold_two_code <= `RST_THRESHOLD_TWO; // [RULE9]
    end else if (wr_threshold) begin
      threshold_two_code <= rio.wr_data; // [RULE1]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dac_config <= `RST_DAC_CONFIG; // [RULE9]
    end else if (wr_config) begin
      dac_config <= rio.wr_data & `CFG_WRITE_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      filter_on <= `RST_CMP_STATUS; // [RULE9]
    end else if (wr_status) begin
      filter_on <= rio.wr_data[3:0]; // [RULE6]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      event_flag <= `RST_CMP_STATUS; // [RULE9]
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (toggle[i]) begin
          event_flag[i] <= 1'b1; // [RULE4] [RULE11]
        end else if (wr_status && !rio.wr_data[`ST_FLAG_LSB + i]) begin
          event_flag[i] <= 1'b0; // [RULE11]
        end
      end
    end
  end

  // Interrupt status is sticky, cleared by writing ones, and set wins.
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_status <= `RST_IRQ;
    end else if (wr_irq_status) begin
      irq_status <= (irq_status & ~rio.wr_data[3:0]) | toggle;
    end else begin
      irq_status <= irq_status | toggle;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_mask <= `RST_IRQ;
    end else if (wr_irq_mask) begin
      irq_mask <= rio.wr_data[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_status | toggle) & irq_mask &
               ~({4{wr_irq_status}} & rio.wr_data[3:0] & ~toggle));
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dac_code             <= `RST_THRESHOLD_TWO;
      dac_output_on        <= 1'b0;
      core_supply_to_cmp_a <= 1'b0;
      dac_loopback_test    <= 1'b0;
      hysteresis_on        <= 4'h0;
    end else begin
      dac_code             <= next_code; // [RULE3]
      dac_output_on        <= next_cfg[`CFG_DAC_ON_BIT];
      core_supply_to_cmp_a <= next_cfg[`CFG_SUPPLY_BIT]; // [RULE7]
      dac_loopback_test    <= next_cfg[`CFG_LOOPBACK_BIT]; // [RULE8]
      hysteresis_on        <= next_cfg[3:0];
    end
  end

  // Pins follow the register value that is stored at the same edge.
  always_comb begin
    next_code = wr_threshold ? rio.wr_data : threshold_two_code;
    next_cfg  = wr_config ? (rio.wr_data & `CFG_WRITE_MASK) : dac_config;
  end

  always_comb begin
    rio.rd_data = 8'h00;
    if (rio.rd_idx == `IDX_THRESHOLD_TWO) begin
      rio.rd_data = threshold_two_code;
    end else if (rio.rd_idx == `IDX_DAC_CONFIG) begin
      rio.rd_data = dac_config;
    end else if (rio.rd_idx == `IDX_CMP_STATUS) begin
      rio.rd_data = {event_flag, live_out}; // [RULE6]
    end else if (rio.rd_idx == `IDX_IRQ_STATUS) begin
      rio.rd_data = {4'h0, irq_status};
    end else if (rio.rd_idx == `IDX_IRQ_MASK) begin
      rio.rd_data = {4'h0, irq_mask};
    end
  end
endmodule

// *** tb/comparator_model.sv ***
// Behavioural model of the four analog comparators behind the block.
`timescale 1ns/1ns
module comparator_model (
  input  wire logic       clk,
  input  wire logic [3:0] level,
  input  wire logic [3:0] glitch,
  input  wire logic [3:0] lag,
  output      logic [3:0] cmp_raw
);
  logic [3:0] held = 4'h0;
  logic [3:0] wait_cnt = 4'h0;

  // A slow comparator follows a new input level only after lag cycles.
  always_ff @(posedge clk) begin
    if (level == held || wait_cnt >= lag) begin
      held     <= level;
      wait_cnt <= 4'h0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end

  assign cmp_raw = held ^ glitch;
endmodule

// *** tb/comparator_status_dac_ctrl_assertions.sv ***
// Port-level assertions for the comparator and threshold DAC block.
`timescale 1ns/1ns
`include "cmp_dac_defines.svh"
module cmp_dac_checker #(
  parameter int ADDR_W     = 18,
  parameter int FILTER_LEN = 16
) (
  input wire logic              clk,
  input wire logic              srst,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic [31:0]       wdata,
  input wire logic [3:0]        wstrb,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic              bvalid,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [31:0]       rdata,
  input wire logic              rvalid,
  input wire logic              rready,
  input wire logic [3:0]        cmp_enable,
  input wire logic [7:0]        dac_code,
  input wire logic              dac_output_on,
  input wire logic              core_supply_to_cmp_a,
  input wire logic              dac_loopback_test,
  input wire logic [3:0]        hysteresis_on,
  input wire logic              irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic        take;
  logic        rd_st;
  logic [15:0] widx;
  logic [7:0]  wbyte;
  logic [14:0] outs;
  assign take  = awvalid && awready && wvalid && wready;
  assign widx  = awaddr[ADDR_W-1:2];
  assign wbyte = wdata[7:0];
  assign outs  = {dac_code, dac_output_on, core_supply_to_cmp_a,
                  dac_loopback_test, hysteresis_on};

  always_ff @(posedge clk) begin
    if (srst)
      rd_st <= 1'b0;
    else if (arvalid && arready)
      rd_st <= araddr[ADDR_W-1:2] == `IDX_CMP_STATUS;
  end

  chk_code_write: assert property (
    take && wstrb[0] && widx == `IDX_THRESHOLD_TWO
    |-> ##2 dac_code == $past(wbyte, 2)) else $error("dac code not written");
  chk_cfg_write: assert property (
    take && wstrb[0] && widx == `IDX_DAC_CONFIG
    |-> ##2 {outs[6:4], 1'b0, outs[3:0]} == ($past(wbyte, 2) & 8'hef))
    else $error("config outputs not written");
  chk_cfg_quiet: assert property (
    $changed(outs) |-> $rose(bvalid)) else $error("output moved alone");
  chk_reset_zero: assert property (
    $fell(srst) |-> outs == 15'h0000 && !irq) else $error("reset not zero");
  chk_live_off: assert property (
    $rose(rvalid) && rd_st
    |-> (rdata[3:0] & ~$past(cmp_enable) & ~$past(cmp_enable, 2)) == 4'h0)
    else $error("disabled comparator reads high");
  chk_read_answer: assert property (
    arvalid && arready |-> ##[1:2] rvalid) else $error("read unanswered");
  chk_busy_refuse: assert property (
    bvalid |-> !awready && !wready) else $error("write taken while busy");
  chk_rdata_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");

  cover property (take && widx == `IDX_THRESHOLD_TWO);
  cover property ($rose(irq));
  cover property ($rose(rvalid) && rd_st && cmp_enable != 4'hf);
endmodule

bind comparator_status_dac_ctrl cmp_dac_checker #(
  .ADDR_W(ADDR_W), .FILTER_LEN(FILTER_LEN)) u_chk (
  .clk, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
  .wready, .bvalid, .araddr, .arvalid, .arready, .rdata, .rvalid, .rready,
  .cmp_enable, .dac_code, .dac_output_on, .core_supply_to_cmp_a,
  .dac_loopback_test, .hysteresis_on, .irq);

// *** tb/tb.sv ***
// Self-checking bench for the comparator and threshold DAC control block.
`timescale 1ns/1ns
`include "cmp_dac_defines.svh"
module tb;
  localparam int          FLEN  = `FILTER_LEN;
  localparam logic [17:0] A_THR = {`IDX_THRESHOLD_TWO, 2'b00};
  localparam logic [17:0] A_CFG = {`IDX_DAC_CONFIG, 2'b00};
  localparam logic [17:0] A_ST  = {`IDX_CMP_STATUS, 2'b00};
  localparam logic [17:0] A_IS  = {`IDX_IRQ_STATUS, 2'b00};
  localparam logic [17:0] A_IM  = {`IDX_IRQ_MASK, 2'b00};
  localparam logic [1:0]  OK    = cmp_dac_pkg::resp_okay;
  localparam logic [1:0]  DEC   = cmp_dac_pkg::resp_decerr;
  logic        clk, srst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        dac_on, sup, lpb, irq;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, level, glitch, lag, cmp_raw, cmp_enable, hyst;
  logic [1:0]  bresp, rresp;
  logic [2:0]  prot;
  logic [7:0]  dac_code;
  logic [15:0] pins;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  int          n_mismatch = 0;
  int          checks = 0;
  int          cycles = 0;
  integer      seed;
  assign pins = {dac_code, dac_on, sup, lpb, hyst, irq};

  comparator_status_dac_ctrl #(.FILTER_LEN(FLEN)) DUT (
    .clk, .srst, .awaddr, .awprot(prot), .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot(prot), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .cmp_raw, .cmp_enable, .dac_code, .dac_output_on(dac_on),
    .core_supply_to_cmp_a(sup), .dac_loopback_test(lpb),
    .hysteresis_on(hyst), .irq);
  comparator_model analog (.clk, .level, .glitch, .lag, .cmp_raw);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic note(input logic ok, input logic [33:0] g, e);
    checks++;
    if (!ok) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_bus(input logic [33:0] g, e);
    note(g === e, g, e);
  endtask
  // Output pins are looked at mid-cycle, away from any update edge.
  task automatic cmp_out(input logic [15:0] g, e);
    @(negedge clk);
    note(pins === e, {18'h0, pins}, {18'h0, e});
  endtask

  always @(posedge clk) begin
    if (bvalid && bready)
      cmp_bus({32'h0, bresp}, {32'h0, bq.pop_front()});
    if (rvalid && rready)
      cmp_bus({rresp, rdata}, rq.pop_front());
  end

  task automatic wr(input logic [17:0] a, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] r);
    logic        ta, tw, hb;
    logic [31:0] rn;
    bq.push_back(r);
    rn = $random(seed);
    @(posedge clk);
    {awaddr, wdata, wstrb, prot} <= {a, rn[31:8], d, s, rn[2:0]};
    {awvalid, wvalid, bready} <= 3'b111;
    hb = 1'b0;
    while (!hb) begin
      @(negedge clk);
      {ta, tw, hb} = {awvalid && awready, wvalid && wready, bvalid};
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [17:0] a, input logic [7:0] e,
                    input logic [1:0] r);
    logic ta, hr;
    rq.push_back({r, 24'h0, e});
    @(posedge clk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    hr = 1'b0;
    while (!hr) begin
      @(negedge clk);
      {ta, hr} = {arvalid && arready, rvalid};
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task automatic done(input string name);
    $display("test %s ended, %0d checks so far", name, checks);
  endtask

  task automatic summarize;
    $display("checks %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    logic [7:0] v;
    seed = 32'hd3c9;
    {awvalid, wvalid, bready, arvalid, rready, prot} = 8'h00;
    {awaddr, araddr, wdata, wstrb, level, glitch, lag} = '0;
    cmp_enable = 4'hf;
    srst = 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 5; i++)
      rd(A_THR + 18'(4 * i), 8'h00, OK);
    rd(18'h280e8, 8'h00, DEC);
    wr(18'h280e8, 8'hff, 4'h1, DEC);
    cmp_out(pins, 16'h0000);
    done("reset");
    for (int i = 0; i < 3; i++) begin
      v = i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($random(seed));
      wr(A_THR, v, 4'h1, OK);
      cmp_out(pins, {v, 8'h00});
      rd(A_THR, v, OK);
    end
    wr(A_THR, 8'h5a, 4'h0, OK);
    rd(A_THR, v, OK);
    wr(A_THR, 8'h00, 4'h1, OK);
    done("threshold");
    wr(A_CFG, 8'hff, 4'h1, OK);
    rd(A_CFG, 8'hef, OK);
    cmp_out(pins, 16'h00fe);
    for (int i = 0; i < 4; i++) begin
      v = i < 3 ? 8'h20 << i : 8'h00;
      wr(A_CFG, v, 4'h1, OK);
      cmp_out(pins, {8'h00, v[7:5], 5'h00});
    end
    done("config");
    wr(A_IM, 8'h0f, 4'h1, OK);
    level <= 4'h5;
    repeat (6) @(posedge clk);
    cmp_out(pins, 16'h0001);
    rd(A_ST, 8'h55, OK);
    rd(A_IS, 8'h05, OK);
    wr(A_ST, 8'hf0, 4'h1, OK);
    rd(A_ST, 8'h55, OK);
    wr(A_IM, 8'h00, 4'h1, OK);
    cmp_out(pins, 16'h0000);
    wr(A_ST, 8'h00, 4'h1, OK);
    rd(A_ST, 8'h05, OK);
    wr(A_IS, 8'h0f, 4'h1, OK);
    wr(A_IM, 8'h0f, 4'h1, OK);
    cmp_out(pins, 16'h0000);
    done("events");
    {lag, cmp_enable, level} <= 12'h33f;
    repeat (10) @(posedge clk);
    rd(A_ST, 8'h23, OK);
    cmp_enable <= 4'hf;
    repeat (4) @(posedge clk);
    wr(A_ST, 8'h00, 4'h1, OK);
    wr(A_IS, 8'h0f, 4'h1, OK);
    rd(A_ST, 8'h0f, OK);
    done("disabled");
    wr(A_ST, 8'h01, 4'h1, OK);
    glitch <= 4'h3;
    repeat (FLEN - 1) @(posedge clk);
    glitch <= 4'h0;
    repeat (FLEN) @(posedge clk);
    rd(A_ST, 8'h2f, OK);
    level <= 4'he;
    rd(A_ST, 8'h2f, OK);
    repeat (FLEN + 4) @(posedge clk);
    rd(A_ST, 8'h3e, OK);
    done("filter");
    summarize();
  end
endmodule
